// File: logic/dsd_params.svh
// constants for the data space decoder
`ifndef DSD_PARAMS_SVH
`define DSD_PARAMS_SVH
`define DSD_CLK_MHZ      200
`define DSD_T_ATOMIC_US  3400
`define DSD_T_SPLIT_US   1800
`define DSD_ATOMIC_CYC   (`DSD_T_ATOMIC_US * `DSD_CLK_MHZ)
`define DSD_SPLIT_CYC    (`DSD_T_SPLIT_US * `DSD_CLK_MHZ)
`define DSD_RF_END       16'h0020
`define DSD_IO_END       16'h0060
`define DSD_EXT_END      16'h0100
`define DSD_SRAM_END     16'h0900
`define DSD_IO_OFS       16'h0020
`define DSD_BIT_LIM      6'h20
`define DSD_PTR_BASE     5'h1A
`define DSD_DS_STAT      8'h3D
`define DSD_DS_SCR0      8'h3E
`define DSD_DS_CTRL      8'h3F
`define DSD_DS_DATA      8'h40
`define DSD_DS_ALO       8'h41
`define DSD_DS_AHI       8'h42
`define DSD_DS_SCR1      8'h4A
`define DSD_DS_SCR2      8'h4B
`define DSD_CTRL_RE      0
`define DSD_CTRL_WE      1
`define DSD_CTRL_MPE     2
`define DSD_CTRL_RIE     3
`define DSD_CTRL_PM      4
`define DSD_RD_STALL     3'h4
`define DSD_WR_STALL     3'h2
`define DSD_MASTER_CYC   3'h4
`define DSD_NVM_ERASED   8'hFF
`endif

// File: logic/dsd_pkg.sv
// types for the data space decoder
package dsd_pkg;
  typedef enum logic [2:0] {
    OP_LOAD  = 3'b000,
    OP_STORE = 3'b001,
    OP_BSET  = 3'b010,
    OP_BCLR  = 3'b011,
    OP_SKIPS = 3'b100,
    OP_SKIPC = 3'b101
  } dsd_op_type;
  typedef enum logic [2:0] {
    MD_DIRECT  = 3'b000,
    MD_DISP    = 3'b001,
    MD_IND     = 3'b010,
    MD_PREDEC  = 3'b011,
    MD_POSTINC = 3'b100
  } dsd_mode_type;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ACC   = 2'b01,
    ST_STALL = 2'b10
  } dsd_state_type;
  typedef struct packed {
    logic         valid;
    logic         io_space;
    dsd_op_type   op;
    dsd_mode_type mode;
    logic [1:0]   ptr;
    logic [15:0]  addr;
    logic [5:0]   io_addr;
    logic [5:0]   disp;
    logic [2:0]   bitn;
    logic [7:0]   wdata;
  } dsd_req_type;
  typedef struct packed {
    logic       done;
    logic       skip;
    logic [7:0] rdata;
  } dsd_resp_type;
endpackage

// File: logic/dsd_data_space_decoder.sv
// data space decoder with register file, sram, i/o window and nonvolatile store
//
// Overview of operation
// (R1) register file, standard, extended windows in order
// (R2) 2K sram above extended window, 2048 locations
// (R3) extended window only by load/store
// (R4) direct mode reaches whole data space
// (R5) displacement: y/z pointer plus up to 63
// (R6) registers 26-31 form three pointers
// (R7) pre-decrement before, post-increment after access
// (R8) all regions reachable in all five modes
// (R9) sram access takes two clocks
// (R10) separate 1K byte nonvolatile store
// (R11) nonvolatile registers sit in standard window
// (R12) self-timed write with visible completion
// (R13) write needs master enable then write enable
// (R14) nonvolatile read stalls cpu four clocks
// (R15) nonvolatile write stalls cpu two clocks
// (R16) write in progress survives system reset
// (R17) short i/o 0x00-0x3F, data space plus 0x20
// (R18) bit ops only at i/o 0x00-0x1F
// (R19) bit ops touch only the addressed bit
// (R20) status flags clear on writing one
// (R21) software writes reserved bits as zero
// (R22) three plain scratch registers
// (R23) busy write blocks reads and address changes
// (R24) unmapped: writes ignored, reads zero
`timescale 1ns/10ps
`include "dsd_params.svh"
module dsd_data_space_decoder #(
  parameter int ATOMIC_CYC = `DSD_ATOMIC_CYC,
  parameter int SPLIT_CYC  = `DSD_SPLIT_CYC
) (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  por,
  input  wire dsd_pkg::dsd_req_type  req,
  output      dsd_pkg::dsd_resp_type resp,
  output      logic                  ready,
  output      logic                  nvm_busy
);
  import dsd_pkg::*;

  logic [7:0]    rf        [0:31];
  logic [7:0]    sram      [0:2047];
  logic [7:0]    nvm       [0:1023];
  logic [7:0]    scratch_r [0:2];
  dsd_state_type state_r;
  dsd_state_type state_nxt;
  dsd_resp_type  resp_r;
  logic          ready_r;
  logic [2:0]    scnt_r;
  dsd_op_type    op_r;
  logic [15:0]   ea_r;
  logic [7:0]    wdata_r;
  logic [2:0]    bit_r;
  logic          bitok_r;
  logic          wb_en_r;
  logic [1:0]    wb_sel_r;
  logic [15:0]   wb_val_r;
  logic [15:0]   ptr_val;
  logic [15:0]   ea_nxt;
  logic [15:0]   wb_nxt;
  logic          wb_en_nxt;
  logic [4:0]    ptr_lo;
  logic          acc;
  logic [7:0]    rd_val;
  logic [7:0]    io_val;
  logic [7:0]    nb;
  logic [7:0]    wmask;
  logic          is_wr;
  logic          in_rf;
  logic          in_io;
  logic          in_sram;
  logic [10:0]   sram_idx;
  logic          io_we;
  logic          master_r;
  logic [2:0]    mcnt_r;
  logic [1:0]    mode_r;
  logic          irqen_r;
  logic [9:0]    naddr_r;
  logic [7:0]    ndata_r;
  logic          flag_r;
  logic          rd_trig;
  logic          wr_start;
  logic          busy_r;
  logic [19:0]   wcnt_r;
  logic [9:0]    waddr_r;
  logic [7:0]    wbyte_r;
  logic          wr_fin;

  // pointer pair lookup
  // (R6) pointer pair select
  assign ptr_lo  = 5'(`DSD_PTR_BASE + {2'b00, req.ptr, 1'b0});
  assign ptr_val = {rf[ptr_lo + 5'h01], rf[ptr_lo]};
  assign acc     = req.valid && ready_r;

  // (R7) address and pointer update
  always_comb begin
    ea_nxt    = req.addr;
    wb_nxt    = ptr_val;
    wb_en_nxt = 1'b0;
    // (R4) direct reaches everything
    unique case (req.mode)
      MD_DIRECT: ea_nxt = req.addr;
      // (R5) base plus displacement
      MD_DISP: ea_nxt = ptr_val + {10'h000, req.disp};
      MD_IND: ea_nxt = ptr_val;
      MD_PREDEC: begin
        ea_nxt    = ptr_val - 16'h0001;
        wb_nxt    = ptr_val - 16'h0001;
        wb_en_nxt = 1'b1;
      end
      MD_POSTINC: begin
        ea_nxt    = ptr_val;
        wb_nxt    = ptr_val + 16'h0001;
        wb_en_nxt = 1'b1;
      end
      default: ea_nxt = req.addr;
    endcase
    // (R17) short i/o offset
    if (req.io_space || (req.op != OP_LOAD && req.op != OP_STORE)) begin
      ea_nxt    = {10'h000, req.io_addr} + `DSD_IO_OFS;
      wb_en_nxt = 1'b0;
    end
  end

  // accept stage
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      op_r     <= OP_LOAD;
      ea_r     <= 16'h0000;
      wdata_r  <= 8'h00;
      bit_r    <= 3'h0;
      bitok_r  <= 1'b0;
      wb_en_r  <= 1'b0;
      wb_sel_r <= 2'h0;
      wb_val_r <= 16'h0000;
    end else if (acc) begin
      op_r     <= req.op;
      ea_r     <= ea_nxt;
      wdata_r  <= req.wdata;
      bit_r    <= req.bitn;
      // (R18) bit window limit
      bitok_r  <= req.io_addr < `DSD_BIT_LIM;
      wb_en_r  <= wb_en_nxt;
      wb_sel_r <= req.ptr;
      wb_val_r <= wb_nxt;
    end
  end

  // (R1) region decode
  assign in_rf    = ea_r < `DSD_RF_END;
  assign in_io    = !in_rf && ea_r < `DSD_IO_END;
  // (R2) sram above extended window
  assign in_sram  = ea_r >= `DSD_EXT_END && ea_r < `DSD_SRAM_END;
  assign sram_idx = 11'(ea_r - `DSD_EXT_END);

  // (R11) nonvolatile registers in standard window
  always_comb begin
    unique case (ea_r[7:0])
      `DSD_DS_CTRL: io_val = {2'b00, mode_r, irqen_r, master_r, busy_r, 1'b0};
      `DSD_DS_DATA: io_val = ndata_r;
      `DSD_DS_ALO:  io_val = naddr_r[7:0];
      `DSD_DS_AHI:  io_val = {6'h00, naddr_r[9:8]};
      `DSD_DS_STAT: io_val = {7'h00, flag_r};
      `DSD_DS_SCR0: io_val = scratch_r[0];
      `DSD_DS_SCR1: io_val = scratch_r[1];
      `DSD_DS_SCR2: io_val = scratch_r[2];
      // (R24) unmapped reads zero
      default:      io_val = 8'h00;
    endcase
  end

  // (R3) extended window has no short path, reads zero
  always_comb begin
    if (in_rf) begin
      rd_val = rf[ea_r[4:0]];
    end else if (in_io) begin
      rd_val = io_val;
    end else if (in_sram) begin
      rd_val = sram[sram_idx];
    end else begin
      rd_val = 8'h00;
    end
  end

  // (R19) single bit read-modify-write
  always_comb begin
    nb    = wdata_r;
    wmask = 8'hFF;
    is_wr = op_r == OP_STORE;
    if (op_r == OP_BSET || op_r == OP_BCLR) begin
      wmask = 8'h01 << bit_r;
      nb    = (op_r == OP_BSET) ? (rd_val | wmask) : (rd_val & ~wmask);
      is_wr = bitok_r;
    end
  end

  assign io_we    = state_r == ST_ACC && is_wr && in_io;
  // (R13) protected write start
  assign wr_start = io_we && ea_r[7:0] == `DSD_DS_CTRL && nb[`DSD_CTRL_WE] && master_r && !busy_r
                    && mode_r != 2'b11;
  // (R23) no read while writing
  assign rd_trig  = io_we && ea_r[7:0] == `DSD_DS_CTRL && nb[`DSD_CTRL_RE] && !busy_r;

  // (R8) register file and pointer writeback
  always_ff @(posedge mclk) begin
    if (state_r == ST_ACC && is_wr && in_rf) begin
      rf[ea_r[4:0]] <= nb;
    end
    if (state_r == ST_ACC && wb_en_r) begin
      rf[5'(`DSD_PTR_BASE + {2'b00, wb_sel_r, 1'b0})]        <= wb_val_r[7:0];
      rf[5'(`DSD_PTR_BASE + {2'b00, wb_sel_r, 1'b0} + 5'h01)] <= wb_val_r[15:8];
    end
  end

  // (R9) sram write in access cycle
  always_ff @(posedge mclk) begin
    if (state_r == ST_ACC && is_wr && in_sram) begin
      sram[sram_idx] <= nb;
    end
  end

  // (R22) scratch storage
  for (genvar g = 0; g < 3; g++) begin : g_scr
    localparam logic [7:0] SCR_ADDR = (g == 0) ? `DSD_DS_SCR0 : (g == 1) ? `DSD_DS_SCR1 : `DSD_DS_SCR2;
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        scratch_r[g] <= 8'h00;
      end else if (io_we && ea_r[7:0] == SCR_ADDR) begin
        scratch_r[g] <= nb;
      end
    end
  end

  // nonvolatile control, data and address registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      master_r <= 1'b0;
      mcnt_r   <= 3'h0;
      mode_r   <= 2'b00;
      irqen_r  <= 1'b0;
      naddr_r  <= 10'h000;
      ndata_r  <= 8'h00;
    end else begin
      // (R13) master enable times out
      if (io_we && ea_r[7:0] == `DSD_DS_CTRL && nb[`DSD_CTRL_MPE] && !wr_start) begin
        master_r <= 1'b1;
        mcnt_r   <= `DSD_MASTER_CYC;
      end else if (mcnt_r == 3'h1) begin
        master_r <= 1'b0;
        mcnt_r   <= 3'h0;
      end else if (mcnt_r != 3'h0) begin
        mcnt_r <= mcnt_r - 3'h1;
      end
      if (io_we && ea_r[7:0] == `DSD_DS_CTRL) begin
        irqen_r <= nb[`DSD_CTRL_RIE];
        if (!busy_r) begin
          mode_r <= nb[`DSD_CTRL_PM +: 2];
        end
      end
      // (R23) address frozen while busy
      if (io_we && ea_r[7:0] == `DSD_DS_ALO && !busy_r) begin
        naddr_r[7:0] <= nb;
      end
      if (io_we && ea_r[7:0] == `DSD_DS_AHI && !busy_r) begin
        naddr_r[9:8] <= nb[1:0];
      end
      // (R10) byte read from separate store
      if (rd_trig) begin
        ndata_r <= nvm[naddr_r];
      end else if (io_we && ea_r[7:0] == `DSD_DS_DATA) begin
        ndata_r <= nb;
      end
    end
  end

  // (R16) write engine cleared only at power-on
  always_ff @(posedge mclk or posedge por) begin
    if (por) begin
      busy_r  <= 1'b0;
      wcnt_r  <= 20'h0_0000;
      waddr_r <= 10'h000;
      wbyte_r <= 8'h00;
    end else if (wr_start) begin
      // (R12) self-timed write
      busy_r  <= 1'b1;
      wcnt_r  <= (mode_r == 2'b00) ? 20'(ATOMIC_CYC) : 20'(SPLIT_CYC);
      waddr_r <= naddr_r;
      unique case (mode_r)
        2'b01:   wbyte_r <= `DSD_NVM_ERASED;
        2'b10:   wbyte_r <= nvm[naddr_r] & ndata_r;
        default: wbyte_r <= ndata_r;
      endcase
    end else if (busy_r) begin
      wcnt_r <= wcnt_r - 20'h0_0001;
      if (wcnt_r == 20'h0_0001) begin
        busy_r <= 1'b0;
      end
    end
  end

  assign wr_fin = busy_r && wcnt_r == 20'h0_0001;

  always_ff @(posedge mclk) begin
    if (wr_fin) begin
      nvm[waddr_r] <= wbyte_r;
    end
  end

  // (R20) write-one clears, set wins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flag_r <= 1'b0;
    end else if (wr_fin) begin
      flag_r <= 1'b1;
    end else if (io_we && ea_r[7:0] == `DSD_DS_STAT && (nb[0] & wmask[0])) begin
      flag_r <= 1'b0;
    end
  end

  // (R14) (R15) access sequencer and stalls
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:  state_nxt = acc ? ST_ACC : ST_IDLE;
      ST_ACC:   state_nxt = (rd_trig || wr_start) ? ST_STALL : ST_IDLE;
      ST_STALL: state_nxt = (scnt_r == 3'h1) ? ST_IDLE : ST_STALL;
      default:  state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      ready_r <= 1'b1;
      scnt_r  <= 3'h0;
    end else begin
      state_r <= state_nxt;
      ready_r <= state_nxt == ST_IDLE;
      if (state_r == ST_ACC) begin
        scnt_r <= rd_trig ? `DSD_RD_STALL : `DSD_WR_STALL;
      end else if (scnt_r != 3'h0) begin
        scnt_r <= scnt_r - 3'h1;
      end
    end
  end

  // (R18) skip test only in bit window
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      resp_r <= '0;
    end else begin
      resp_r.done <= state_r == ST_ACC;
      if (state_r == ST_ACC) begin
        resp_r.rdata <= rd_val;
        resp_r.skip  <= bitok_r && (op_r == OP_SKIPS || op_r == OP_SKIPC)
                        && (rd_val[bit_r] == (op_r == OP_SKIPS));
      end
    end
  end

  assign resp     = resp_r;
  assign ready    = ready_r;
  assign nvm_busy = busy_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_stall4;
    !ready_r [*4] ##1 ready_r;
  endsequence
  sequence s_stall2;
    !ready_r [*2] ##1 ready_r;
  endsequence

  property p_sram_two;
    acc |=> state_r == ST_ACC ##1 resp_r.done;
  endproperty
  a_sram_two: assert property (p_sram_two) else $error("access not answered in two cycles"); // (R9)

  property p_rd_stall;
    state_r == ST_ACC && rd_trig |=> s_stall4;
  endproperty
  a_rd_stall: assert property (p_rd_stall) else $error("read stall not four cycles"); // (R14)

  property p_wr_stall;
    state_r == ST_ACC && wr_start |=> s_stall2;
  endproperty
  a_wr_stall: assert property (p_wr_stall) else $error("write stall not two cycles"); // (R15)

  property p_need_master;
    $rose(busy_r) |-> $past(master_r);
  endproperty
  a_need_master: assert property (p_need_master) else $error("write began without master enable"); // (R13)

  property p_addr_hold;
    busy_r && $past(busy_r) |-> $stable(naddr_r);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address changed during write"); // (R23)

  property p_ext_zero;
    state_r == ST_ACC && !in_rf && !in_io && !in_sram |=> resp_r.rdata == 8'h00;
  endproperty
  a_ext_zero: assert property (p_ext_zero) else $error("unmapped read not zero"); // (R24)

  property p_predec;
    acc && req.mode == MD_PREDEC && !req.io_space && req.op inside {OP_LOAD, OP_STORE}
      |=> ea_r == $past(ptr_val) - 16'h0001;
  endproperty
  a_predec: assert property (p_predec) else $error("pre-decrement address wrong"); // (R7)

  property p_flag_set;
    wr_fin |=> flag_r;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("completion flag lost"); // (R20)

  property p_master_end;
    $rose(master_r) |-> master_r [*4] ##1 !master_r;
  endproperty
  a_master_end: assert property (p_master_end) else $error("master enable window wrong"); // (R13)
endmodule

// File: tb/dsd_cpu_model.sv
// cpu side model issuing data space and short i/o requests
`timescale 1ns/10ps
module dsd_cpu_model (
  input  wire logic                  mclk,
  input  wire logic                  ready,
  input  wire dsd_pkg::dsd_resp_type resp,
  output      dsd_pkg::dsd_req_type  req
);
  import dsd_pkg::*;

  initial req = '0;

  // present, hold until taken, then wait for done and end of stall
  task automatic xfer(input dsd_req_type r, output logic [7:0] rd, output logic sk, output int lat,
                      output int st);
    int n;
    n = 0;
    r.valid = 1'b1;
    @(posedge mclk);
    req <= r;
    do begin
      @(posedge mclk);
      n++;
    end while (ready !== 1'b1 && n < 64);
    // released fields never keep the last value
    req <= dsd_req_type'(~r);
    lat = 0;
    do begin
      @(posedge mclk);
      #1;
      lat++;
    end while (resp.done !== 1'b1 && lat < 64);
    rd = resp.rdata;
    sk = resp.skip;
    st = 0;
    while (ready !== 1'b1 && st < 32) begin
      @(posedge mclk);
      #1;
      st++;
    end
  endtask
endmodule

// File: tb/dsd_data_space_decoder_test.sv
// self-checking bench for the data space decoder
`timescale 1ns/10ps
module dsd_data_space_decoder_test;
  import dsd_pkg::*;
  // whole run needs well under a thousand cycles
  localparam int LIMIT = 6000;
  logic         mclk;
  logic         rst;
  logic         por;
  logic         ready;
  logic         nvm_busy;
  dsd_req_type  req;
  dsd_resp_type resp;
  logic [7:0]   rdv;
  logic         skv;
  int           latv;
  int           stv;
  int           n_fail;
  int           samples_checked;
  int           cyc;

  dsd_data_space_decoder #(.ATOMIC_CYC(40), .SPLIT_CYC(20)) i_dsd_data_space_decoder (
    .mclk(mclk), .rst(rst), .por(por), .req(req), .resp(resp), .ready(ready), .nvm_busy(nvm_busy));
  dsd_cpu_model i_dsd_cpu_model (.mclk(mclk), .ready(ready), .resp(resp), .req(req));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic acc(input logic io, input dsd_op_type op, input dsd_mode_type md, input logic [1:0] p,
                     input logic [15:0] a, input logic [5:0] d, input logic [2:0] b, input logic [7:0] w);
    dsd_req_type r;
    r = '0;
    r.io_space = io;
    r.op = op;
    r.mode = md;
    r.ptr = p;
    r.addr = a;
    r.io_addr = a[5:0];
    r.disp = d;
    r.bitn = b;
    r.wdata = w;
    i_dsd_cpu_model.xfer(r, rdv, skv, latv, stv);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] w);
    acc(1'b0, OP_STORE, MD_DIRECT, 2'd0, a, 6'h00, 3'h0, w);
  endtask

  task automatic rd(input logic [15:0] a);
    acc(1'b0, OP_LOAD, MD_DIRECT, 2'd0, a, 6'h00, 3'h0, 8'h00);
  endtask

  task automatic bop(input dsd_op_type op, input logic [5:0] a, input logic [2:0] b);
    acc(1'b1, op, MD_DIRECT, 2'd0, {10'h000, a}, 6'h00, b, 8'h00);
  endtask

  task automatic t_map;
    wr(16'h0005, 8'h77);
    rd(16'h0005);
    check("regfile", rdv, 8'h77);
    wr(16'h0100, 8'h3C);
    check("sram latency", 8'(latv), 8'h01);
    check("sram stall", 8'(stv), 8'h00);
    wr(16'h08FF, 8'hC3);
    rd(16'h0100);
    check("sram low", rdv, 8'h3C);
    rd(16'h08FF);
    check("sram top", rdv, 8'hC3);
    wr(16'h0080, 8'h55);
    rd(16'h0080);
    check("ext window", rdv, 8'h00);
    wr(16'h0900, 8'h55);
    rd(16'h0900);
    check("above sram", rdv, 8'h00);
    $display("test map done");
  endtask

  task automatic t_ptr;
    int          p;
    logic [7:0]  b;
    logic [15:0] a;
    for (p = 0; p < 3; p++) begin
      b = 8'h1A + 8'(2 * p);
      a = 16'h0400 + 16'(p * 16);
      wr(16'(b), a[7:0]);
      wr(16'(b + 8'h01), a[15:8]);
      acc(1'b0, OP_STORE, MD_POSTINC, 2'(p), 16'h0000, 6'h00, 3'h0, 8'hA0 + 8'(p));
      rd(a);
      check("postinc data", rdv, 8'hA0 + 8'(p));
      rd(16'(b));
      check("postinc ptr", rdv, a[7:0] + 8'h01);
      acc(1'b0, OP_STORE, MD_PREDEC, 2'(p), 16'h0000, 6'h00, 3'h0, 8'hB0 + 8'(p));
      rd(16'(b));
      check("predec ptr", rdv, a[7:0]);
      acc(1'b0, OP_LOAD, MD_IND, 2'(p), 16'h0000, 6'h00, 3'h0, 8'h00);
      check("ind load", rdv, 8'hB0 + 8'(p));
      if (p > 0) begin
        acc(1'b0, OP_STORE, MD_DISP, 2'(p), 16'h0000, 6'h3F, 3'h0, 8'hC0 + 8'(p));
        rd(a + 16'h003F);
        check("disp store", rdv, 8'hC0 + 8'(p));
      end
    end
    wr(16'h001A, 8'h05);
    wr(16'h001B, 8'h00);
    acc(1'b0, OP_LOAD, MD_IND, 2'd0, 16'h0000, 6'h00, 3'h0, 8'h00);
    check("ind regfile", rdv, 8'h77);
    wr(16'h001E, 8'h3E);
    wr(16'h001F, 8'h00);
    acc(1'b0, OP_STORE, MD_DISP, 2'd2, 16'h0000, 6'h00, 3'h0, 8'h5C);
    rd(16'h003E);
    check("disp io", rdv, 8'h5C);
    $display("test pointer done");
  endtask

  task automatic t_io;
    acc(1'b1, OP_STORE, MD_DIRECT, 2'd0, 16'h001E, 6'h00, 3'h0, 8'h81);
    rd(16'h003E);
    check("io offset", rdv, 8'h81);
    acc(1'b1, OP_STORE, MD_DIRECT, 2'd0, 16'h002A, 6'h00, 3'h0, 8'h12);
    rd(16'h004A);
    check("scratch one", rdv, 8'h12);
    acc(1'b1, OP_STORE, MD_DIRECT, 2'd0, 16'h002B, 6'h00, 3'h0, 8'h34);
    acc(1'b1, OP_LOAD, MD_DIRECT, 2'd0, 16'h002B, 6'h00, 3'h0, 8'h00);
    check("scratch two", rdv, 8'h34);
    bop(OP_BSET, 6'h1E, 3'd3);
    rd(16'h003E);
    check("bit set", rdv, 8'h89);
    bop(OP_BCLR, 6'h1E, 3'd0);
    rd(16'h003E);
    check("bit clear", rdv, 8'h88);
    bop(OP_SKIPS, 6'h1E, 3'd3);
    check("skip on set", {7'h00, skv}, 8'h01);
    bop(OP_SKIPC, 6'h1E, 3'd3);
    check("no skip", {7'h00, skv}, 8'h00);
    bop(OP_SKIPC, 6'h1E, 3'd0);
    check("skip on clear", {7'h00, skv}, 8'h01);
    bop(OP_BSET, 6'h2A, 3'd0);
    rd(16'h004A);
    check("bit op high io", rdv, 8'h12);
    bop(OP_SKIPS, 6'h2A, 3'd1);
    check("skip high io", {7'h00, skv}, 8'h00);
    $display("test io done");
  endtask

  // arm, strobe with mode bits md[5:4], wait out the write
  task automatic nv_prog(input logic [7:0] md);
    int n;
    wr(16'h003F, md | 8'h04);
    wr(16'h003F, md | 8'h02);
    for (n = 0; n < 200 && nvm_busy !== 1'b0; n++) @(posedge mclk);
  endtask

  task automatic nv_read;
    wr(16'h003F, 8'h01);
    rd(16'h0040);
  endtask

  task automatic t_nvm;
    int n;
    acc(1'b1, OP_STORE, MD_DIRECT, 2'd0, 16'h0021, 6'h00, 3'h0, 8'h05);
    wr(16'h0042, 8'h00);
    wr(16'h0040, 8'h5A);
    wr(16'h003F, 8'h02);
    check("no master", {7'h00, nvm_busy}, 8'h00);
    wr(16'h003F, 8'h04);
    repeat (6) @(posedge mclk);
    wr(16'h003F, 8'h02);
    check("master lapsed", {7'h00, nvm_busy}, 8'h00);
    wr(16'h003F, 8'h04);
    wr(16'h003F, 8'h06);
    check("write stall", 8'(stv), 8'h02);
    check("busy", {7'h00, nvm_busy}, 8'h01);
    wr(16'h0041, 8'h07);
    rd(16'h0041);
    check("addr locked", rdv, 8'h05);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    check("busy in reset", {7'h00, nvm_busy}, 8'h01);
    rst <= 1'b0;
    for (n = 0; n < 200 && nvm_busy !== 1'b0; n++) @(posedge mclk);
    check("write ends", {7'h00, nvm_busy}, 8'h00);
    rd(16'h003D);
    check("done flag", rdv & 8'h01, 8'h01);
    wr(16'h003D, 8'h01);
    rd(16'h003D);
    check("flag cleared", rdv & 8'h01, 8'h00);
    wr(16'h0041, 8'h05);
    wr(16'h0042, 8'h00);
    wr(16'h003F, 8'h01);
    check("read stall", 8'(stv), 8'h04);
    rd(16'h0040);
    check("stored byte", rdv, 8'h5A);
    wr(16'h0040, 8'h3C);
    nv_prog(8'h20);
    nv_read;
    check("write only", rdv, 8'h18);
    nv_prog(8'h10);
    nv_read;
    check("erase only", rdv, 8'hFF);
    nv_prog(8'h30);
    check("reserved mode", 8'(stv), 8'h00);
    nv_read;
    check("reserved keeps", rdv, 8'hFF);
    $display("test nonvolatile done");
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      end_sim;
    end
  end

  initial begin
    rst = 1'b1;
    por = 1'b1;
    n_fail = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    por <= 1'b0;
    t_map;
    t_ptr;
    t_io;
    t_nvm;
    end_sim;
  end
endmodule
